// [logic/fcpwm_consts.vh]
// Offsets, field positions and reset values for the four-channel PWM unit.
// Included by the unit's single design file; holds definitions only.
`ifndef FCPWM_CONSTS_VH
`define FCPWM_CONSTS_VH
// Register offsets on the 8-bit register port.
`define FCPWM_ADDR_W 8
`define FCPWM_OFF_CLKPOL 8'h41
`define FCPWM_OFF_PRESC 8'h40
`define FCPWM_OFF_ENABLE 8'h42
`define FCPWM_OFF_SCALE0 8'h44
`define FCPWM_OFF_SCALE1 8'h45
`define FCPWM_OFF_CENTER 8'h46
`define FCPWM_OFF_CNT_BASE 8'h48
`define FCPWM_OFF_PER_BASE 8'h4c
`define FCPWM_OFF_DTY_BASE 8'h50
// Fields of the prescale and pairing control register.
`define FCPWM_JOIN_UPPER 7
`define FCPWM_JOIN_LOWER 6
`define FCPWM_PSA_LSB 3
`define FCPWM_PSB_LSB 0
// Reset values.
`define FCPWM_RST_BYTE 8'h00
`define FCPWM_RST_PER 8'hff
`endif

// [logic/fcpwm_unit.v]
// Four-channel pulse-width modulator with pair concatenation, prescalers and scalers.
// Assumes a single 250 MHz clock acting as E clock and a one-cycle strobe register port.
// Function
// - Four 8-bit channels, joinable as two 16-bit or one 16-bit plus two 8-bit.
// - Each channel has its own counter, period value and duty value.
// - Counters clock from four sources chosen per channel.
// - Duty spans zero to full; channels run continuously and independently.
// - Each output may be left-aligned or center-aligned.
// - Period and duty are double buffered; load at rollover or disable.
// - While disabled, writes reach buffer and active latch together.
// - Counter write clears counter and latches pending period and duty.
// - Channel counter is readable by software.
// - Enabled channel overrides general-purpose use of its port pin.
// - Upper join: ch2 high byte, ch3 low byte, output bit 2, ch3 clock.
// - Lower join: ch0 high byte, ch1 low byte, output bit 0, ch1 clock.
// - Clock A is E divided by two to the 3-bit field.
// - Clock B uses the same power-of-two division from its own field.
// - Channels 2,3: select 0 picks clock B, 1 picks scaled clock S1.
// - Channels 0,1: select 0 picks clock A, 1 picks scaled clock S0.
// - Clock select change may produce one truncated or stretched pulse.
// - Start-high bit 0: begin low, rise at duty; 1: begin high, fall.
// - Clock-select/polarity register: selects 7:4, polarity 3:0, RW, resets zero.
// - Scaled clock is prescaled clock over scale+1, over two; write reloads.
// - Enable forces pin to output; waveform starts at next selected tick.
// - Left-aligned resets on period match; center-aligned reverses on match.
// - Duty at or above period leaves the output unchanged for the period.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "fcpwm_consts.vh"
module fcpwm_unit (
	// Clock and reset.
	input wire sys_clk,
	input wire rst,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// General-purpose port that the channels share.
	input wire [3:0] gp_out,
	input wire [3:0] gp_dir_out,
	input wire [3:0] pin_in,
	output wire [3:0] pin_out,
	output wire [3:0] pin_oe_n,
	output wire [3:0] gp_in
);
	reg [7:0] prescale_and_pairing_control;
	reg [7:0] channel_clock_and_polarity;
	reg [3:0] channel_output_enable;
	reg [3:0] center_align_select;
	reg [7:0] lower_scale_value;
	reg [7:0] upper_scale_value;
	reg [6:0] prescale_cnt;
	reg [7:0] lower_scale_cnt;
	reg [7:0] upper_scale_cnt;
	reg lower_scaled_clock;
	reg upper_scaled_clock;
	reg [7:0] channel_counter [0:3];
	reg [7:0] channel_period_value [0:3];
	reg [7:0] channel_duty_value [0:3];
	reg [7:0] act_per [0:3];
	reg [7:0] act_dty [0:3];
	reg [3:0] count_down;
	reg [3:0] wave;
	reg [3:0] running;
	reg [3:0] pin_sync1;
	reg [3:0] pin_sync2;
	reg [3:0] pin_sync3;
	reg [3:0] pin_stable;
	wire join_upper_pair = prescale_and_pairing_control[`FCPWM_JOIN_UPPER];
	wire join_lower_pair = prescale_and_pairing_control[`FCPWM_JOIN_LOWER];
	wire [2:0] first_prescale_select = prescale_and_pairing_control[`FCPWM_PSA_LSB +: 3];
	wire [2:0] second_prescale_select = prescale_and_pairing_control[`FCPWM_PSB_LSB +: 3];
	wire [3:0] scaled_sel = channel_clock_and_polarity[7:4];
	wire [3:0] start_high = channel_clock_and_polarity[3:0];
	wire [7:0] next_prescale_cnt = {1'b0, prescale_cnt} + 8'h01;
	// Bit k toggles once every 2^k cycles, so index k ticks at E over 2^k; bit 7 is the carry out.
	wire [7:0] presc_carry = {next_prescale_cnt[7], next_prescale_cnt[6:1] ^ prescale_cnt[6:1],
		1'b1};
	wire tick_a = presc_carry[first_prescale_select];
	wire tick_b = presc_carry[second_prescale_select];
	// Scaler ticks: one per scaled clock period, on its high-to-low toggle; toggled every (scale+1) prescaled ticks.
	wire lower_scale_hit = tick_a && (lower_scale_cnt == 8'h00);
	wire upper_scale_hit = tick_b && (upper_scale_cnt == 8'h00);
	wire tick_s0 = lower_scale_hit && lower_scaled_clock;
	wire tick_s1 = upper_scale_hit && upper_scaled_clock;
	wire any_en = |channel_output_enable;
	wire cnt_wr = reg_wr && (reg_addr[7:2] == `FCPWM_OFF_CNT_BASE >> 2);
	wire per_wr = reg_wr && (reg_addr[7:2] == `FCPWM_OFF_PER_BASE >> 2);
	wire dty_wr = reg_wr && (reg_addr[7:2] == `FCPWM_OFF_DTY_BASE >> 2);
	wire [1:0] wr_ch = reg_addr[1:0];
	wire [3:0] tick;
	wire [3:0] lead;
	wire [3:0] pair_on;
	wire [3:0] roll;
	wire [3:0] chan_out;
	// Next 16-bit count of each leading channel; a joined high byte copies its partner's top half.
	wire [15:0] cnt_nx [0:3];
	wire [3:0] cnt_adv;
	// Prescaler: free-running 7-bit counter, idled when every channel is off to save power.
	always @(posedge sys_clk) begin
		if (rst) begin
			prescale_cnt <= 7'h00;
		end else if (any_en) begin
			prescale_cnt <= next_prescale_cnt[6:0];
		end
	end
	// Scaler down-counters; a write to a scale register reloads its counter at once.
	always @(posedge sys_clk) begin
		if (rst) begin
			lower_scale_cnt <= `FCPWM_RST_BYTE;
			upper_scale_cnt <= `FCPWM_RST_BYTE;
			lower_scaled_clock <= 1'b0;
			upper_scaled_clock <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `FCPWM_OFF_SCALE0) begin
				lower_scale_cnt <= reg_wdata;
			end else if (lower_scale_hit) begin
				lower_scale_cnt <= lower_scale_value;
				lower_scaled_clock <= ~lower_scaled_clock;
			end else if (tick_a) begin
				lower_scale_cnt <= lower_scale_cnt - 8'h01;
			end
			if (reg_wr && reg_addr == `FCPWM_OFF_SCALE1) begin
				upper_scale_cnt <= reg_wdata;
			end else if (upper_scale_hit) begin
				upper_scale_cnt <= upper_scale_value;
				upper_scaled_clock <= ~upper_scaled_clock;
			end else if (tick_b) begin
				upper_scale_cnt <= upper_scale_cnt - 8'h01;
			end
		end
	end
	// Control registers, all readable and writable at any time.
	always @(posedge sys_clk) begin
		if (rst) begin
			prescale_and_pairing_control <= `FCPWM_RST_BYTE;
			channel_clock_and_polarity <= `FCPWM_RST_BYTE;
			channel_output_enable <= 4'h0;
			center_align_select <= 4'h0;
			lower_scale_value <= `FCPWM_RST_BYTE;
			upper_scale_value <= `FCPWM_RST_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
				`FCPWM_OFF_PRESC: prescale_and_pairing_control <= reg_wdata;
				`FCPWM_OFF_CLKPOL: channel_clock_and_polarity <= reg_wdata;
				`FCPWM_OFF_ENABLE: channel_output_enable <= reg_wdata[3:0];
				`FCPWM_OFF_CENTER: center_align_select <= reg_wdata[3:0];
				`FCPWM_OFF_SCALE0: lower_scale_value <= reg_wdata;
				`FCPWM_OFF_SCALE1: upper_scale_value <= reg_wdata;
				default: prescale_and_pairing_control <= prescale_and_pairing_control;
			endcase
		end
	end
	// Per-channel datapath; in a joined pair the low-byte channel leads and its partner follows.
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			localparam integer HI = (i % 2 == 0) ? 1 : 0;
			localparam integer LO = i | 1;
			localparam integer HICH = i & 2;
			wire joined = (i < 2) ? join_lower_pair : join_upper_pair;
			// Clock source: prescaled A/B or scaled S0/S1; joined pairs use the low channel's choice.
			wire src_tick_a = scaled_sel[joined ? LO : i] ? tick_s0 : tick_a;
			wire src_tick_b = scaled_sel[joined ? LO : i] ? tick_s1 : tick_b;
			assign tick[i] = (i < 2) ? src_tick_a : src_tick_b;
			assign pair_on[i] = joined ? channel_output_enable[HICH] : channel_output_enable[i];
			assign lead[i] = ~joined || (i == LO);
			// Full 16-bit view in a joined pair, else the channel's own byte with zero above.
			wire [15:0] cnt16 = joined ? {channel_counter[HICH], channel_counter[LO]}
				: {8'h00, channel_counter[i]};
			wire [15:0] per16 = joined ? {act_per[HICH], act_per[LO]} : {8'h00, act_per[i]};
			wire [15:0] dty16 = joined ? {act_dty[HICH], act_dty[LO]} : {8'h00, act_dty[i]};
			wire center = center_align_select[joined ? HICH : i];
			wire per_hit = (cnt16 == per16);
			wire zero_hit = (cnt16 == 16'h0000);
			wire step = running[i] && tick[i];
			wire [15:0] next_cnt16 = (count_down[i] ? cnt16 - 16'h0001 : cnt16 + 16'h0001);
			wire [15:0] up_cnt16 = cnt16 + 16'h0001;
			wire [15:0] dn_cnt16 = cnt16 - 16'h0001;
			// Rollover: end of left period, or return to zero when counting down.
			assign roll[i] = step && (center ? (count_down[i] && zero_hit) : per_hit);
			assign cnt_adv[i] = lead[i] && step;
			assign cnt_nx[i] = (!center && per_hit) ? 16'h0000
				: (center && !count_down[i] && per_hit) ? dn_cnt16
				: (center && count_down[i] && zero_hit) ? up_cnt16
				: next_cnt16;
			wire own_buf = (i == HICH || !joined || HI == 0);
			wire dis = !pair_on[i];
			wire load_act = roll[joined ? LO : i] || dis || (cnt_wr && wr_ch == i[1:0]);
			always @(posedge sys_clk) begin
				if (rst) begin
					channel_counter[i] <= `FCPWM_RST_BYTE;
					channel_period_value[i] <= `FCPWM_RST_PER;
					channel_duty_value[i] <= `FCPWM_RST_PER;
					act_per[i] <= `FCPWM_RST_PER;
					act_dty[i] <= `FCPWM_RST_PER;
					count_down[i] <= 1'b0;
					running[i] <= 1'b0;
					wave[i] <= 1'b0;
				end else begin
					// Buffers; while disabled the active latches follow in the same cycle.
					if (per_wr && wr_ch == i[1:0]) begin
						channel_period_value[i] <= reg_wdata;
					end
					if (dty_wr && wr_ch == i[1:0]) begin
						channel_duty_value[i] <= reg_wdata;
					end
					if (dis && per_wr && wr_ch == i[1:0]) begin
						act_per[i] <= reg_wdata;
					end else if (load_act && own_buf) begin
						act_per[i] <= channel_period_value[i];
					end
					if (dis && dty_wr && wr_ch == i[1:0]) begin
						act_dty[i] <= reg_wdata;
					end else if (load_act && own_buf) begin
						act_dty[i] <= channel_duty_value[i];
					end
					// Waveform begins only on the first selected tick after enabling.
					if (dis) begin
						running[i] <= 1'b0;
					end else if (tick[joined ? LO : i]) begin
						running[i] <= 1'b1;
					end
					// Each channel writes only its own counter byte, so every byte has one driver.
					if (cnt_wr && wr_ch == i[1:0]) begin
						channel_counter[i] <= 8'h00;
						count_down[i] <= 1'b0;
						wave[i] <= start_high[i];
					end else if (cnt_adv[i]) begin
						channel_counter[i] <= cnt_nx[i][7:0];
						if (!center && per_hit) begin
							wave[i] <= start_high[joined ? HICH : i];
						end else if (center && !count_down[i] && per_hit) begin
							count_down[i] <= 1'b1;
						end else if (center && count_down[i] && zero_hit) begin
							count_down[i] <= 1'b0;
							wave[i] <= start_high[joined ? HICH : i];
						end
						// Duty match flips; duty at or past period never matches.
						if (cnt16 == dty16 && dty16 < per16) begin
							wave[i] <= ~start_high[joined ? HICH : i];
						end
					end else begin
						if (joined && HI == 1 && cnt_adv[LO]) begin
							channel_counter[i] <= cnt_nx[LO][15:8];
						end
						if (dis) begin
							wave[i] <= start_high[i];
						end
					end
				end
			end
			// Pin output: joined pairs drive the high-byte channel's pin from the low lead.
			assign chan_out[i] = joined ? ((i == HICH) ? wave[LO] : 1'b0) : wave[i];
		end
	endgenerate
	// Three-stage pin sampling; a change counts once stages two and three agree.
	always @(posedge sys_clk) begin
		if (rst) begin
			pin_sync1 <= 4'h0;
			pin_sync2 <= 4'h0;
			pin_sync3 <= 4'h0;
			pin_stable <= 4'h0;
		end else begin
			pin_sync1 <= pin_in;
			pin_sync2 <= pin_sync1;
			pin_sync3 <= pin_sync2;
			pin_stable <= (pin_sync2 == pin_sync3) ? pin_sync3 : pin_stable;
		end
	end
	// Enabled channels take the pin and force it to drive; otherwise the port owns it.
	assign pin_out = (channel_output_enable & chan_out) | (~channel_output_enable & gp_out);
	assign pin_oe_n = ~(channel_output_enable | gp_dir_out);
	assign gp_in = pin_stable;
	// Read data in the cycle after the strobe; counters read without disturbing them.
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr[7:2] == `FCPWM_OFF_CNT_BASE >> 2) begin
				reg_rdata <= channel_counter[wr_ch];
			end else if (reg_addr[7:2] == `FCPWM_OFF_PER_BASE >> 2) begin
				reg_rdata <= channel_period_value[wr_ch];
			end else if (reg_addr[7:2] == `FCPWM_OFF_DTY_BASE >> 2) begin
				reg_rdata <= channel_duty_value[wr_ch];
			end else begin
				case (reg_addr)
					`FCPWM_OFF_PRESC: reg_rdata <= prescale_and_pairing_control;
					`FCPWM_OFF_CLKPOL: reg_rdata <= channel_clock_and_polarity;
					`FCPWM_OFF_ENABLE: reg_rdata <= {4'h0, channel_output_enable};
					`FCPWM_OFF_SCALE0: reg_rdata <= lower_scale_value;
					`FCPWM_OFF_SCALE1: reg_rdata <= upper_scale_value;
					`FCPWM_OFF_CENTER: reg_rdata <= {4'h0, center_align_select};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // fcpwm_unit

// [testbench/fcpwm_unit_assertions.sv]
// Concurrent checks on the PWM unit's register port and shared pin control.
// Assumes the register map of fcpwm_consts.vh and a bind onto fcpwm_unit.
`timescale 1ns/1ps
`include "fcpwm_consts.vh"
module fcpwm_chk (
	// Clock and reset.
	input wire sys_clk,
	input wire rst,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Shared port.
	input wire [3:0] gp_out,
	input wire [3:0] gp_dir_out,
	input wire [3:0] pin_out,
	input wire [3:0] pin_oe_n
);
	reg [3:0] en_seen;
	// Shadow of the enable bits, so pin control can be judged from the ports alone.
	always @(posedge sys_clk) begin
		if (rst)
			en_seen <= 4'h0;
		else if (reg_wr && reg_addr == `FCPWM_OFF_ENABLE)
			en_seen <= reg_wdata[3:0];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// A write, one idle cycle, then a read of the same place.
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	sequence s_wr_rd(a);
		s_wr(a) ##1 !reg_wr ##1 (reg_rd && reg_addr == a);
	endsequence
	property p_back(a);
		s_wr_rd(a) |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_clkpol_back: assert property (p_back(8'h41)) else $error("clkpol readback");
	a_presc_back: assert property (p_back(8'h40)) else $error("presc readback");
	a_scale_back: assert property (p_back(8'h44)) else $error("scale readback");
	a_period_back: assert property (p_back(8'h4c)) else $error("period readback");
	a_duty_back: assert property (p_back(8'h50)) else $error("duty readback");
	// A counter read just after its write can have advanced two ticks at most.
	a_count_clear: assert property (s_wr_rd(8'h48) |=> reg_rdata <= 8'h02)
		else $error("counter not cleared");
	a_pin_override: assert property (pin_oe_n == ~(gp_dir_out | en_seen))
		else $error("pin direction wrong");
	a_gp_pass: assert property (((pin_out ^ gp_out) & ~en_seen) == 4'h0)
		else $error("port data not passed");
endmodule // fcpwm_chk
bind fcpwm_unit fcpwm_chk fcpwm_chk_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.gp_out(gp_out), .gp_dir_out(gp_dir_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// [testbench/fcpwm_pin_load.sv]
// External load on the shared port pins: resolves each pin from the unit's drive.
// Assumes the bench sets the outside level used while the unit lets a pin go.
`timescale 1ns/1ps
module fcpwm_pin_load (
	// Unit side.
	input wire [3:0] pin_out,
	input wire [3:0] pin_oe_n,
	// Outside drive and resolved level.
	input wire [3:0] ext_drive,
	output wire [3:0] pin_level
);
	// A released pin shows the outside level, never a stale copy of the unit's drive.
	assign pin_level = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule // fcpwm_pin_load

// [testbench/tb_top.sv]
// Self-checking bench for the four-channel PWM unit.
// Assumes the register map of fcpwm_consts.vh and a 250 MHz clock.
`timescale 1ns/1ps
module tb_top;
	reg sys_clk = 1'b0;
	reg rst = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [3:0] gp_out = 4'h0;
	reg [3:0] gp_dir_out = 4'h0;
	reg [3:0] ext_drive = 4'h5;
	wire [7:0] reg_rdata;
	wire [3:0] pin_level, pin_out, pin_oe_n, gp_in;
	int err_count = 0;
	int n_tests = 0;
	int per, hi;
	// Half period of 2 ns gives the 4 ns clock.
	always #2 sys_clk = ~sys_clk;
	fcpwm_unit fcpwm_unit_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gp_out(gp_out), .gp_dir_out(gp_dir_out), .pin_in(pin_level), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .gp_in(gp_in));
	fcpwm_pin_load fcpwm_pin_load_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_drive(ext_drive), .pin_level(pin_level));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 check(what, {8'h00, reg_rdata}, {8'h00, exp});
	endtask
	// Period and duty, then a counter write so both latch at once.
	task automatic cfg(input int c, input logic [7:0] p, input logic [7:0] d);
		wr(8'h4c + 8'(c), p);
		wr(8'h50 + 8'(c), d);
		wr(8'h48 + 8'(c), 8'h00);
	endtask
	// Period and high time of one pin, rising edge to rising edge, bounded.
	task automatic meas(input int b);
		int n;
		logic l;
		n = 0;
		per = 0;
		hi = 0;
		while (pin_out[b] !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		do begin
			l = pin_out[b];
			hi += (l === 1'b1);
			per++;
			n++;
			@(negedge sys_clk);
		end while (!(l === 1'b0 && pin_out[b] === 1'b1) && n < 3000);
	endtask
	task automatic t_regs;
		rd_chk("clkpol_rst", 8'h41, 8'h00);
		rd_chk("per_rst", 8'h4c, 8'hff);
		rd_chk("unmapped", 8'h43, 8'h00);
		wr(8'h41, 8'ha5);
		rd_chk("clkpol", 8'h41, 8'ha5);
		wr(8'h44, 8'h37);
		rd_chk("scale0", 8'h44, 8'h37);
		wr(8'h40, 8'hff);
		rd_chk("presc", 8'h40, 8'hff);
		wr(8'h4c, 8'h34);
		rd_chk("period", 8'h4c, 8'h34);
		wr(8'h50, 8'h12);
		rd_chk("duty", 8'h50, 8'h12);
		wr(8'h48, 8'h77);
		rd_chk("counter", 8'h48, 8'h00);
		wr(8'h40, 8'h00);
		wr(8'h41, 8'h00);
	endtask
	task automatic t_presc;
		cfg(0, 8'h04, 8'h01);
		cfg(2, 8'h04, 8'h01);
		wr(8'h42, 8'h05);
		for (int k = 0; k < 8; k++) begin
			wr(8'h40, 8'(k * 9));
			meas(0);
			meas(0);
			check("per_a", 16'(per), 16'(5 << k));
			check("hi_a", 16'(hi), 16'(3 << k));
			meas(2);
			meas(2);
			check("per_b", 16'(per), 16'(5 << k));
		end
		wr(8'h41, 8'h05);
		wr(8'h40, 8'h00);
		meas(0);
		meas(0);
		check("hi_pol", 16'(hi), 16'd2);
	endtask
	// Duty equal to period: the pin must hold its start level.
	task automatic t_flat(input logic [7:0] pol, input int exp);
		int ones;
		wr(8'h41, pol);
		cfg(0, 8'h04, 8'h04);
		ones = 0;
		repeat (40) begin
			@(negedge sys_clk);
			ones += (pin_out[0] === 1'b1);
		end
		check("flat", 16'(ones), 16'(exp));
	endtask
	task automatic t_scaled;
		wr(8'h41, 8'h50);
		wr(8'h40, 8'h09);
		wr(8'h44, 8'h02);
		wr(8'h45, 8'h02);
		cfg(0, 8'h04, 8'h01);
		cfg(2, 8'h04, 8'h01);
		meas(0);
		meas(0);
		check("per_s0", 16'(per), 16'd60);
		meas(2);
		meas(2);
		check("per_s1", 16'(per), 16'd60);
		wr(8'h41, 8'h00);
		wr(8'h40, 8'h00);
	endtask
	task automatic t_center;
		wr(8'h46, 8'h01);
		cfg(0, 8'h04, 8'h01);
		meas(0);
		meas(0);
		check("per_center", 16'(per), 16'd8);
		wr(8'h46, 8'h00);
		cfg(0, 8'h04, 8'h01);
	endtask
	// Old settings would be high eight counts after the counter write.
	task automatic t_latch;
		cfg(0, 8'h20, 8'h10);
		repeat (9) @(negedge sys_clk);
		check("latch", {15'h0, pin_out[0]}, 16'h0000);
	endtask
	task automatic t_join;
		for (int p = 0; p < 4; p += 2) begin
			wr(8'h42, 8'h00);
			wr(8'h40, (p == 2) ? 8'h80 : 8'h40);
			cfg(p, 8'h01, 8'h00);
			cfg(p + 1, 8'h00, 8'h80);
			wr(8'h42, 8'(1 << p));
			meas(p);
			meas(p);
			check("per_join", 16'(per), 16'd257);
			check("hi_join", 16'(hi), 16'd128);
		end
		wr(8'h42, 8'h00);
		wr(8'h40, 8'h00);
	endtask
	task automatic t_gp;
		@(posedge sys_clk);
		gp_dir_out <= 4'hf;
		gp_out <= 4'h9;
		@(negedge sys_clk);
		check("gp_drive", {12'h0, pin_out}, 16'h0009);
		@(posedge sys_clk);
		gp_dir_out <= 4'h0;
		ext_drive <= 4'h6;
		repeat (8) @(negedge sys_clk);
		check("gp_in", {12'h0, gp_in}, 16'h0006);
		wr(8'h42, 8'h01);
		@(negedge sys_clk);
		check("oe_force", {12'h0, pin_oe_n}, 16'h000e);
	endtask
	task automatic summarize;
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence after 16 cycles of reset.
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_presc;
		t_flat(8'h05, 40);
		t_flat(8'h00, 0);
		t_scaled;
		t_center;
		t_latch;
		t_join;
		t_gp;
		summarize;
	end
	// Watchdog: the scenarios need well under the 50000-cycle limit.
	initial begin
		#200000;
		err_count++;
		summarize;
	end
endmodule // tb_top
